// >>> hdl/uvcs_ctl_stats.sv
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/10ps
module uvcs_ctl_stats #(
	parameter int unsigned NUM = uvcs_pkg::NUM_STATS
) (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [7:0]                   paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic                         setup_valid,
	input  wire uvcs_pkg::uvcs_setup_t        setup,
	output logic                              ep0_stall,
	output logic                              ep0_done,
	input  wire logic                         out_valid,
	input  wire logic [31:0]                  out_data,
	output logic                              in_valid,
	output logic      [31:0]                  in_data,
	output logic                              in_last,
	input  wire logic                         in_ready,
	output logic                              csr_wr,
	output logic                              csr_rd,
	output logic      [uvcs_pkg::ADDR_W-1:0]  csr_addr,
	output logic      [31:0]                  csr_wdata,
	input  wire logic                         csr_rd_valid,
	input  wire logic [31:0]                  csr_rdata,
	input  wire logic                         lite_soft_reset,
	input  wire logic                         rx_evt_valid,
	input  wire uvcs_pkg::uvcs_rx_evt_t       rx_evt,
	input  wire logic [NUM-1:0]               ext_inc,
	input  wire logic [31:0]                  ext_amt,
	input  wire logic                         tx_auto_resp
);

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_WR_DATA = 3'b001,
		ST_RD_WAIT = 3'b010,
		ST_RD_SEND = 3'b011,
		ST_SNAP    = 3'b100,
		ST_ST_SEND = 3'b101
	} uvcs_state_t;

	uvcs_state_t       state_q;
	uvcs_state_t       state_d;
	logic [5:0]        word_q;
	logic              store_bad_q;
	logic              vlan_size_enforce_q;
	logic [13:0]       max_size_q;
	logic [15:0]       vlan_ethertype_setting_q;
	logic              lite_pulse_q;
	logic [7:0]        stall_cnt_q;
	logic [31:0]       cnt_q  [NUM];
	logic [31:0]       snap_q [NUM];
	logic [NUM-1:0]    rx_inc;
	logic [31:0]       rx_amt;
	logic              apb_wr;
	logic              apb_rd;
	logic              is_wr;
	logic              is_rd;
	logic              is_st;
	logic              is_stall;
	logic              clr_cnt;

	// apb slave, zero wait states
	assign pready = 1'b1;
	assign apb_wr = psel & penable & pwrite;
	assign apb_rd = psel & ~pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			store_bad_q              <= 1'b0;
			vlan_size_enforce_q      <= 1'b0;
			max_size_q               <= uvcs_pkg::RST_MAX_SIZE;
			vlan_ethertype_setting_q <= uvcs_pkg::RST_VLAN_ETHERTYPE;
			lite_pulse_q             <= 1'b0;
		end else begin
			lite_pulse_q <= 1'b0;
			if (apb_wr) begin
				case (paddr)
					uvcs_pkg::OFS_RX_FIFO_CONTROL: begin
						store_bad_q         <= pwdata[uvcs_pkg::BIT_STORE_BAD];
						vlan_size_enforce_q <= pwdata[uvcs_pkg::BIT_VLAN_ENFORCE];
						lite_pulse_q        <= pwdata[uvcs_pkg::BIT_LITE_RESET];
					end
					uvcs_pkg::OFS_MAC_RX_LIMIT:   max_size_q <= pwdata[13:0];
					uvcs_pkg::OFS_VLAN_ETHERTYPE: vlan_ethertype_setting_q <= pwdata[15:0];
					default: ;
				endcase
			end
		end
	end

	// read data registered in setup phase so it is stable in access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel & ~penable) begin
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			case (paddr)
				uvcs_pkg::OFS_RX_FIFO_CONTROL:
					prdata <= {30'h0, vlan_size_enforce_q, store_bad_q};
				uvcs_pkg::OFS_MAC_RX_LIMIT:   prdata <= {18'h0, max_size_q};
				uvcs_pkg::OFS_VLAN_ETHERTYPE: prdata <= {16'h0, vlan_ethertype_setting_q};
				uvcs_pkg::OFS_CTL_STATUS:
					prdata <= {16'h0, stall_cnt_q, 2'h0, word_q[5:0] == 6'h0, 2'h0, state_q};
				default: pslverr <= apb_rd | pwrite;
			endcase
		end
	end

	// setup decode
	always_comb begin
		is_wr = setup.req_type == uvcs_pkg::TYPE_VEND_OUT &&
			setup.request == uvcs_pkg::REQ_WRITE && setup.value == 16'h0000 &&
			setup.length == uvcs_pkg::LEN_WORD && setup.index[15:13] == 3'h0;
		is_rd = setup.req_type == uvcs_pkg::TYPE_VEND_IN &&
			setup.request == uvcs_pkg::REQ_READ && setup.value == 16'h0000 &&
			setup.length == uvcs_pkg::LEN_WORD && setup.index[15:13] == 3'h0;
		is_st = setup.req_type == uvcs_pkg::TYPE_VEND_IN &&
			setup.request == uvcs_pkg::REQ_STATS && setup.value == 16'h0000 &&
			setup.index == 16'h0000 && setup.length == uvcs_pkg::LEN_STATS;
		// other standard requests belong to the standard handler, not here
		is_stall = (setup.req_type[6:5] == uvcs_pkg::KIND_STD &&
			setup.request == uvcs_pkg::REQ_SYNC) ||
			(setup.req_type[6:5] == uvcs_pkg::KIND_VEND && !is_wr && !is_rd && !is_st);
	end

	// control transfer sequencing; a fresh setup always aborts the old one
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:    ;
			ST_WR_DATA: if (out_valid) state_d = ST_IDLE;
			ST_RD_WAIT: if (csr_rd_valid) state_d = ST_RD_SEND;
			ST_RD_SEND: if (in_ready) state_d = ST_IDLE;
			ST_SNAP:    state_d = ST_ST_SEND;
			ST_ST_SEND: if (in_ready && word_q == 6'(NUM - 1)) state_d = ST_IDLE;
			default:    state_d = ST_IDLE;
		endcase
		if (setup_valid) begin
			if (is_wr) state_d = ST_WR_DATA;
			else if (is_rd) state_d = ST_RD_WAIT;
			else if (is_st) state_d = ST_SNAP;
			else state_d = ST_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) state_q <= ST_IDLE;
		else state_q <= state_d;
	end

	// handshake outputs are decoded straight from state and the word pointer
	assign in_valid = state_q == ST_RD_SEND || state_q == ST_ST_SEND;
	assign in_last  = state_q == ST_RD_SEND || word_q == 6'(NUM - 1);

	// csr strobes, address and stall/done pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			csr_wr      <= 1'b0;
			csr_rd      <= 1'b0;
			csr_addr    <= '0;
			csr_wdata   <= 32'h0000_0000;
			ep0_stall   <= 1'b0;
			ep0_done    <= 1'b0;
			stall_cnt_q <= 8'h00;
		end else begin
			csr_wr    <= 1'b0;
			csr_rd    <= 1'b0;
			ep0_stall <= setup_valid & is_stall;
			ep0_done  <= 1'b0;
			if (setup_valid && is_stall) stall_cnt_q <= stall_cnt_q + 8'h01;
			if (setup_valid && (is_wr || is_rd)) begin
				csr_addr <= setup.index[uvcs_pkg::ADDR_W-1:0];
				csr_rd   <= is_rd;
			end
			if (!setup_valid && state_q == ST_WR_DATA && out_valid) begin
				csr_wr    <= 1'b1;
				csr_wdata <= out_data;
				ep0_done  <= 1'b1;
			end
			if (!setup_valid && in_valid && in_ready && state_d == ST_IDLE) ep0_done <= 1'b1;
		end
	end

	// in data and word pointer; one word only for a register read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_data <= 32'h0000_0000;
			word_q  <= 6'h00;
		end else begin
			if (state_q == ST_RD_WAIT && csr_rd_valid) in_data <= csr_rdata;
			if (state_q == ST_SNAP) begin
				in_data <= snap_q[0];
				word_q  <= 6'h00;
			end else if (state_q == ST_ST_SEND && in_ready && word_q != 6'(NUM - 1)) begin
				in_data <= snap_q[word_q + 6'h01];
				word_q  <= word_q + 6'h01;
			end
		end
	end

	// receive frame classification
	logic [13:0] limit;
	logic        tag1;
	logic        tag2;
	logic        bad;
	logic        errored;
	logic        short_f;
	logic        long_f;
	logic        deliver;
	logic [13:0] len;

	always_comb begin
		len  = rx_evt.len;
		tag1 = rx_evt.type1 == uvcs_pkg::VLAN_TPID ||
			rx_evt.type1 == vlan_ethertype_setting_q;
		tag2 = tag1 && (rx_evt.type2 == uvcs_pkg::VLAN_TPID ||
			rx_evt.type2 == vlan_ethertype_setting_q);
		limit = max_size_q;
		if (vlan_size_enforce_q)
			limit = max_size_q + (tag2 ? uvcs_pkg::TWO_TAGS :
				tag1 ? uvcs_pkg::ONE_TAG : 14'h0000);
		// length is whole bytes, so stray bits never push it over
		long_f  = len > limit;
		short_f = len < uvcs_pkg::MIN_FRAME;
		bad     = rx_evt.fcs_err | rx_evt.rx_err;
		errored = bad | rx_evt.align_err;
		deliver = !rx_evt.dropped && (!errored || store_bad_q);
		rx_inc  = '0;
		rx_amt  = {18'h0, len};
		if (rx_evt_valid) begin
			rx_inc[uvcs_pkg::IDX_FCS]    = bad && !short_f && !long_f;
			rx_inc[uvcs_pkg::IDX_ALIGN]  = rx_evt.align_err;
			rx_inc[uvcs_pkg::IDX_FRAG]   = bad && short_f;
			rx_inc[uvcs_pkg::IDX_JABBER] = bad && long_f;
			rx_inc[uvcs_pkg::IDX_UNDER]  = !errored && short_f;
			rx_inc[uvcs_pkg::IDX_OVER]   = !errored && long_f;
			rx_inc[uvcs_pkg::IDX_DROP]   = rx_evt.dropped && (!errored || store_bad_q);
			if (deliver) begin
				if (rx_evt.is_bcast) begin
					rx_inc[uvcs_pkg::IDX_UC_BYTE + 1] = 1'b1;
					rx_inc[uvcs_pkg::IDX_UC_FRM + 1]  = 1'b1;
				end else if (rx_evt.is_mcast) begin
					rx_inc[uvcs_pkg::IDX_UC_BYTE + 2] = 1'b1;
					rx_inc[uvcs_pkg::IDX_UC_FRM + 2]  = 1'b1;
				end else begin
					rx_inc[uvcs_pkg::IDX_UC_BYTE] = 1'b1;
					rx_inc[uvcs_pkg::IDX_UC_FRM]  = 1'b1;
				end
				rx_inc[uvcs_pkg::IDX_PAUSE]    = rx_evt.is_pause;
				rx_inc[uvcs_pkg::IDX_BIN0]     = len == uvcs_pkg::MIN_FRAME;
				rx_inc[uvcs_pkg::IDX_BIN0 + 1] = len >= uvcs_pkg::BIN1_LO && len < uvcs_pkg::BIN2_LO;
				rx_inc[uvcs_pkg::IDX_BIN0 + 2] = len >= uvcs_pkg::BIN2_LO && len < uvcs_pkg::BIN3_LO;
				rx_inc[uvcs_pkg::IDX_BIN0 + 3] = len >= uvcs_pkg::BIN3_LO && len < uvcs_pkg::BIN4_LO;
				rx_inc[uvcs_pkg::IDX_BIN0 + 4] = len >= uvcs_pkg::BIN4_LO && len < uvcs_pkg::BIN5_LO;
				rx_inc[uvcs_pkg::IDX_BIN0 + 5] = len >= uvcs_pkg::BIN5_LO && len < uvcs_pkg::BIN6_LO;
				rx_inc[uvcs_pkg::IDX_BIN0 + 6] = len >= uvcs_pkg::BIN6_LO;
			end
		end
	end

	// lite reset clears counters like a hard reset does
	assign clr_cnt = lite_soft_reset | lite_pulse_q;

	// one counter and one snapshot word per statistics slot
	for (genvar i = 0; i < NUM; i++) begin : g_cnt
		logic        inc;
		logic [31:0] amt;
		logic [31:0] mask;
		logic [31:0] sum;
		// suspended auto replies would otherwise skew host traffic figures
		assign inc  = (i < uvcs_pkg::NUM_RX_DER) ? rx_inc[i] :
			ext_inc[i] & !(i >= uvcs_pkg::IDX_TX0 && tx_auto_resp);
		assign amt  = !uvcs_pkg::WIDE_SLOTS[i] ? 32'h0000_0001 :
			(i < uvcs_pkg::NUM_RX_DER) ? rx_amt : ext_amt;
		assign mask = uvcs_pkg::WIDE_SLOTS[i] ? 32'hFFFF_FFFF : 32'h000F_FFFF;
		assign sum  = (cnt_q[i] + amt) & mask;

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) cnt_q[i] <= 32'h0000_0000;
			else if (clr_cnt) cnt_q[i] <= 32'h0000_0000;
			else if (inc) cnt_q[i] <= sum;
		end

		// whole set copied in one edge so words agree with each other
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) snap_q[i] <= 32'h0000_0000;
			else if (setup_valid && is_st) snap_q[i] <= cnt_q[i];
		end
	end

endmodule : uvcs_ctl_stats

// >>> hdl/uvcs_pkg.sv
package uvcs_pkg;

	// setup packet fields as handed over by the device controller
	typedef struct packed {
		logic [7:0]  req_type;
		logic [7:0]  request;
		logic [15:0] value;
		logic [15:0] index;
		logic [15:0] length;
	} uvcs_setup_t;

	// one received frame as seen by the receive path
	typedef struct packed {
		logic [13:0] len;
		logic        fcs_err;
		logic        rx_err;
		logic        align_err;
		logic        dropped;
		logic        is_bcast;
		logic        is_mcast;
		logic        is_pause;
		logic [15:0] type1;
		logic [15:0] type2;
	} uvcs_rx_evt_t;

	// request fields
	localparam logic [7:0]  TYPE_VEND_OUT = 8'h40;
	localparam logic [7:0]  TYPE_VEND_IN  = 8'hC0;
	localparam logic [7:0]  REQ_WRITE     = 8'hA0;
	localparam logic [7:0]  REQ_READ      = 8'hA1;
	localparam logic [7:0]  REQ_STATS     = 8'hA2;
	localparam logic [7:0]  REQ_SYNC      = 8'h0C;
	localparam logic [1:0]  KIND_STD      = 2'h0;
	localparam logic [1:0]  KIND_VEND     = 2'h2;
	localparam logic [15:0] LEN_WORD      = 16'h0004;
	localparam logic [15:0] LEN_STATS     = 16'h00BC;
	localparam int unsigned ADDR_W        = 13;

	// statistics slots, one 32-bit word each
	localparam int unsigned NUM_STATS   = 47;
	localparam int unsigned IDX_FCS     = 0;
	localparam int unsigned IDX_ALIGN   = 1;
	localparam int unsigned IDX_FRAG    = 2;
	localparam int unsigned IDX_JABBER  = 3;
	localparam int unsigned IDX_UNDER   = 4;
	localparam int unsigned IDX_OVER    = 5;
	localparam int unsigned IDX_DROP    = 6;
	localparam int unsigned IDX_UC_BYTE = 7;
	localparam int unsigned IDX_UC_FRM  = 10;
	localparam int unsigned IDX_PAUSE   = 13;
	localparam int unsigned IDX_BIN0    = 14;
	localparam int unsigned NUM_RX_DER  = 21;
	localparam int unsigned IDX_TX0     = 23;
	localparam int unsigned CNT_NARROW  = 20;
	localparam int unsigned CNT_WIDE    = 32;

	// slots that hold byte counts or times run 32 bits wide
	localparam logic [NUM_STATS-1:0] WIDE_SLOTS = 47'h4003_8440_0380;

	// frame size limits in bytes
	localparam logic [13:0] MIN_FRAME  = 14'h0040;
	localparam logic [13:0] BIN1_LO    = 14'h0041;
	localparam logic [13:0] BIN2_LO    = 14'h0080;
	localparam logic [13:0] BIN3_LO    = 14'h0100;
	localparam logic [13:0] BIN4_LO    = 14'h0200;
	localparam logic [13:0] BIN5_LO    = 14'h0400;
	localparam logic [13:0] BIN6_LO    = 14'h05EF;
	localparam logic [13:0] ONE_TAG    = 14'h0004;
	localparam logic [13:0] TWO_TAGS   = 14'h0008;
	localparam logic [15:0] VLAN_TPID  = 16'h8100;

	// apb register map
	localparam logic [7:0]  OFS_RX_FIFO_CONTROL = 8'h00;
	localparam logic [7:0]  OFS_MAC_RX_LIMIT    = 8'h04;
	localparam logic [7:0]  OFS_VLAN_ETHERTYPE  = 8'h08;
	localparam logic [7:0]  OFS_CTL_STATUS      = 8'h0C;
	localparam int unsigned BIT_STORE_BAD       = 0;
	localparam int unsigned BIT_VLAN_ENFORCE    = 1;
	localparam int unsigned BIT_LITE_RESET      = 31;
	localparam logic [13:0] RST_MAX_SIZE        = 14'h05EE;
	localparam logic [15:0] RST_VLAN_ETHERTYPE  = 16'h8100;

endpackage : uvcs_pkg

// >>> bench/uvcs_ctl_stats_properties.sv
`timescale 1ns/10ps
module uvcs_ctl_stats_chk (
	input wire logic                        pclk,
	input wire logic                        presetn,
	input wire logic                        setup_valid,
	input wire uvcs_pkg::uvcs_setup_t       setup,
	input wire logic                        ep0_stall,
	input wire logic                        ep0_done,
	input wire logic                        in_valid,
	input wire logic [31:0]                 in_data,
	input wire logic                        in_last,
	input wire logic                        in_ready,
	input wire logic                        csr_wr,
	input wire logic                        csr_rd,
	input wire logic [uvcs_pkg::ADDR_W-1:0] csr_addr
);
	logic                        hdr_ok;
	logic [uvcs_pkg::ADDR_W-1:0] idx_q;
	// fields shared by single-word requests
	assign hdr_ok = setup.value == 16'h0 && setup.index[15:13] == 3'h0 && setup.length == 16'h4;
	// last setup address, so csr_addr can be tied to its cause
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_q <= '0;
		end else if (setup_valid) begin
			idx_q <= setup.index[12:0];
		end
	end
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_SYNC_STALL: assert property (setup_valid && setup.req_type == 8'h00
		&& setup.request == 8'h0C |=> ep0_stall) else $error("sync frame not stalled");
	AST_BAD_CODE: assert property (setup_valid && setup.req_type == 8'hC0
		&& !(setup.request inside {8'hA1, 8'hA2}) |=> ep0_stall) else $error("bad code");
	AST_BAD_WR: assert property (setup_valid && setup.req_type == 8'h40
		&& setup.request == 8'hA0 && !hdr_ok |=> ep0_stall) else $error("bad write kept");
	AST_WR_ACCEPT: assert property (setup_valid && setup.req_type == 8'h40
		&& setup.request == 8'hA0 && hdr_ok |=> !ep0_stall) else $error("good write stalled");
	AST_RD_ONE: assert property (setup_valid && setup.req_type == 8'hC0
		&& setup.request == 8'hA1 && hdr_ok |=> csr_rd && !ep0_stall && csr_addr == idx_q
		##1 !csr_rd) else $error("read not single word");
	AST_ST_START: assert property (setup_valid && setup.req_type == 8'hC0
		&& setup.request == 8'hA2 && setup.value == 16'h0 && setup.index == 16'h0
		&& setup.length == 16'hBC |=> !ep0_stall ##1 (in_valid && !in_last))
		else $error("stats start wrong");
	AST_IN_HOLD: assert property (in_valid && !in_ready && !setup_valid
		|=> in_valid && $stable(in_data) && $stable(in_last)) else $error("in word moved");
	AST_WR_DONE: assert property (csr_wr |-> ep0_done && !csr_rd)
		else $error("write without done");
	AST_WR_ONE: assert property (csr_wr |=> !csr_wr) else $error("burst write");
	AST_IN_DONE: assert property (in_valid && in_ready && in_last && !setup_valid
		|=> ep0_done && !in_valid) else $error("in stage not closed");
	// main scenarios reached
	COV_STALL: cover property (ep0_stall);
	COV_WR: cover property (csr_wr);
	COV_LAST: cover property (in_valid && in_ready && in_last);
endmodule : uvcs_ctl_stats_chk

bind uvcs_ctl_stats uvcs_ctl_stats_chk u_chk (
	.pclk, .presetn, .setup_valid, .setup, .ep0_stall, .ep0_done, .in_valid, .in_data,
	.in_last, .in_ready, .csr_wr, .csr_rd, .csr_addr
);

// >>> bench/uvcs_csr_model.sv
`timescale 1ns/10ps
module uvcs_csr_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        slow,
	input  wire logic        csr_wr,
	input  wire logic        csr_rd,
	input  wire logic [12:0] csr_addr,
	input  wire logic [31:0] csr_wdata,
	output logic             csr_rd_valid,
	output logic [31:0]      csr_rdata
);
	logic [31:0] mem [logic [12:0]];
	logic [12:0] addr_q;
	int          wait_q;
	// register space: one word per request, answer after 1 or 6 cycles
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q <= 0;
			csr_rd_valid <= 1'h0;
			csr_rdata <= 32'h0;
		end else begin
			csr_rd_valid <= 1'h0;
			csr_rdata <= ~csr_rdata; // idle data churns so stale values never pass
			if (wait_q > 0) begin
				wait_q <= wait_q - 1;
			end
			if (csr_wr) begin
				mem[csr_addr] = csr_wdata;
			end
			if (csr_rd) begin
				addr_q <= csr_addr;
				wait_q <= slow ? 6 : 1;
			end
			if (wait_q == 1) begin
				csr_rd_valid <= 1'h1;
				csr_rdata <= mem.exists(addr_q) ? mem[addr_q] : 32'h0;
			end
		end
	end
endmodule : uvcs_csr_model

// >>> bench/tb.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
	$display("Error %s exp %0h got %0h", n, e, g); end end
module tb;
	typedef struct packed {
		logic [13:0] len;
		logic [2:0]  err;
		logic        drop;
		logic [15:0] t1;
		logic [15:0] t2;
		logic [3:0]  slot;
	} uvcs_row_t;
	logic                   pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic                   pwrite = 1'h0, setup_valid = 1'h0, out_valid = 1'h0;
	logic                   in_ready = 1'h0, lite_soft_reset = 1'h0, rx_evt_valid = 1'h0;
	logic                   tx_auto_resp = 1'h0, slow = 1'h0;
	logic [7:0]             paddr = 8'h0;
	logic [31:0]            pwdata = 32'h0, out_data = 32'h0, ext_amt = 32'h0;
	logic [46:0]            ext_inc = 47'h0;
	uvcs_pkg::uvcs_setup_t  setup = '0;
	uvcs_pkg::uvcs_rx_evt_t rx_evt = '0;
	logic [31:0]            prdata, in_data, csr_wdata, csr_rdata, rd;
	logic                   pready, pslverr, ep0_stall, ep0_done, in_valid, in_last, er;
	logic                   csr_wr, csr_rd, csr_rd_valid;
	logic [12:0]            csr_addr;
	logic [31:0]            got [47];
	logic [31:0]            exp [47] = '{default: 32'h0};
	int                     bad_count = 0;
	int                     samples_checked = 0;
	// ordinary frames: length, {fcs,rx,align}, drop, tags, slot bumped (F none)
	uvcs_row_t rows [14] = '{
		'{14'h003C, 3'h4, 1'h0, 16'h0, 16'h0, 4'h2}, '{14'h003C, 3'h0, 1'h0, 16'h0, 16'h0, 4'h4},
		'{14'h003C, 3'h2, 1'h0, 16'h0, 16'h0, 4'h2}, '{14'h0064, 3'h4, 1'h0, 16'h0, 16'h0, 4'h0},
		'{14'h0064, 3'h2, 1'h0, 16'h0, 16'h0, 4'h0}, '{14'h0064, 3'h1, 1'h0, 16'h0, 16'h0, 4'h1},
		'{14'h05EF, 3'h4, 1'h0, 16'h0, 16'h0, 4'h3}, '{14'h05EE, 3'h4, 1'h0, 16'h0, 16'h0, 4'h0},
		'{14'h05EF, 3'h0, 1'h0, 16'h0, 16'h0, 4'h5}, '{14'h05EE, 3'h0, 1'h0, 16'h0, 16'h0, 4'hF},
		'{14'h0064, 3'h0, 1'h1, 16'h0, 16'h0, 4'h6}, '{14'h0064, 3'h4, 1'h1, 16'h0, 16'h0, 4'h0},
		'{14'h05F2, 3'h0, 1'h0, 16'h8100, 16'h0, 4'hF},
		'{14'h05F7, 3'h0, 1'h0, 16'h8100, 16'h8100, 4'h5}
	};
	uvcs_pkg::uvcs_setup_t bad [5] = '{
		'{8'h00, 8'h0C, 16'h0, 16'h0, 16'h0}, '{8'hC0, 8'hA3, 16'h0, 16'h0, 16'h4},
		'{8'h40, 8'hA0, 16'h0, 16'h0, 16'h8}, '{8'hC0, 8'hA1, 16'h1, 16'h0, 16'h4},
		'{8'h40, 8'hA0, 16'h0, 16'h2000, 16'h4}
	};

	uvcs_ctl_stats dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .setup_valid, .setup, .ep0_stall, .ep0_done, .out_valid, .out_data,
		.in_valid, .in_data, .in_last, .in_ready, .csr_wr, .csr_rd, .csr_addr, .csr_wdata,
		.csr_rd_valid, .csr_rdata, .lite_soft_reset, .rx_evt_valid, .rx_evt, .ext_inc,
		.ext_amt, .tx_auto_resp
	);
	uvcs_csr_model csr (
		.pclk, .presetn, .slow, .csr_wr, .csr_rd, .csr_addr, .csr_wdata, .csr_rd_valid,
		.csr_rdata
	);

	// 100 MHz
	always #5 pclk = ~pclk;

	// apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	// one setup pulse; returns once a stall would be visible
	task automatic req(input uvcs_pkg::uvcs_setup_t s);
		@(posedge pclk);
		setup_valid <= 1'h1;
		setup <= s;
		@(posedge pclk);
		setup_valid <= 1'h0;
		#1;
	endtask : req

	task automatic evt(input logic [13:0] l, input logic [2:0] e, input logic dr,
			input logic [15:0] t1, input logic [15:0] t2);
		@(posedge pclk);
		rx_evt_valid <= 1'h1;
		rx_evt <= '{l, e[2], e[1], e[0], dr, 1'h0, 1'h0, 1'h0, t1, t2};
		@(posedge pclk);
		rx_evt_valid <= 1'h0;
	endtask : evt

	// take n in words; at word hold the host stalls while a jabber frame lands
	task automatic ins(input int n, input int hold);
		int w;
		in_ready <= 1'h1;
		for (int i = 0; i < n; i++) begin
			if (i == hold) begin
				in_ready <= 1'h0;
				evt(14'h0640, 3'h4, 1'h0, 16'h0, 16'h0);
				in_ready <= 1'h1;
			end
			w = 0;
			do begin
				@(posedge pclk);
				w++;
			end while (in_valid !== 1'h1 && w < 60);
			`CHK("valid", 1'h1, in_valid)
			got[i] = in_data;
			`CHK("last", (i == n - 1), in_last)
		end
		in_ready <= 1'h0;
	endtask : ins

	task automatic stats(input int hold);
		req('{8'hC0, 8'hA2, 16'h0, 16'h0, 16'hBC});
		ins(47, hold);
	endtask : stats

	// error slots 0-6 and ext-driven slots 22 and 23, or every slot
	task automatic cmp(input logic all);
		for (int i = 0; i < 47; i++) begin
			if (all || i < 7 || i == 22 || i == 23) begin
				`CHK("slot", exp[i], got[i])
			end
		end
	endtask : cmp

	task automatic bump(input int s, input logic [31:0] a, input logic q);
		@(posedge pclk);
		ext_inc <= 47'h1 << s;
		ext_amt <= a;
		tx_auto_resp <= q;
		@(posedge pclk);
		ext_inc <= 47'h0;
	endtask : bump

	task automatic results;
		$display("checks %0d errors %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, 8'h04, 32'h0);
		`CHK("max size", 32'h5EE, rd)
		apb(1'h0, 8'h10, 32'h0);
		`CHK("unmapped", 1'h1, er)
		apb(1'h1, 8'h00, 32'h2);
		foreach (rows[i]) begin
			evt(rows[i].len, rows[i].err, rows[i].drop, rows[i].t1, rows[i].t2);
			if (rows[i].slot != 4'hF) exp[rows[i].slot]++;
		end
		stats(99);
		cmp(1'h0);
		// second tag type, store bad frames on
		apb(1'h1, 8'h08, 32'h88A8);
		apb(1'h0, 8'h08, 32'h0);
		`CHK("ethertype", 32'h88A8, rd)
		apb(1'h1, 8'h00, 32'h3);
		evt(14'h05F2, 3'h0, 1'h0, 16'h88A8, 16'h0);
		evt(14'h05F3, 3'h0, 1'h0, 16'h88A8, 16'h0);
		evt(14'h0064, 3'h4, 1'h1, 16'h0, 16'h0);
		exp[5]++;
		exp[0]++;
		exp[6]++;
		stats(1);
		cmp(1'h0);
		exp[3]++;
		bump(22, 32'hFFFF_FFFF, 1'h0);
		bump(22, 32'h2, 1'h0);
		bump(23, 32'h1, 1'h1);
		bump(23, 32'h1, 1'h0);
		exp[22] = 32'h1;
		exp[23] = 32'h1;
		stats(99);
		cmp(1'h0);
		foreach (bad[i]) begin
			req(bad[i]);
			`CHK("stall", 1'h1, ep0_stall)
		end
		req('{8'h40, 8'hA0, 16'h0, 16'h1ABC, 16'h4});
		`CHK("stall", 1'h0, ep0_stall)
		@(posedge pclk);
		out_valid <= 1'h1;
		out_data <= 32'hC0DE_5A11;
		@(posedge pclk);
		out_valid <= 1'h0;
		for (int s = 0; s < 2; s++) begin
			slow <= s[0];
			req('{8'hC0, 8'hA1, 16'h0, 16'h1ABC, 16'h4});
			ins(1, 99);
			`CHK("read", 32'hC0DE_5A11, got[0])
		end
		@(posedge pclk);
		lite_soft_reset <= 1'h1;
		@(posedge pclk);
		lite_soft_reset <= 1'h0;
		exp = '{default: 32'h0};
		stats(99);
		cmp(1'h1);
		evt(14'h0064, 3'h4, 1'h0, 16'h0, 16'h0);
		apb(1'h1, 8'h00, 32'h8000_0000);
		stats(99);
		cmp(1'h1);
		results();
	end

	// watchdog well past the expected run
	initial begin
		#500000;
		bad_count++;
		results();
	end
endmodule : tb
